// ---- rtl/vcg_consts.svh ----
`ifndef VCG_CONSTS_SVH
`define VCG_CONSTS_SVH

`define VCG_OFF_G2_CTL 8'h15
`define VCG_OFF_G3_MASK 8'h16
`define VCG_OFF_G3_LEVEL 8'h17
`define VCG_OFF_G3_CTL 8'h18
`define VCG_OFF_SECOND_GROUP_ID 8'h19
`define VCG_OFF_FIRST_GROUP_ID 8'h1a
`define VCG_OFF_OWN_ADDR 8'h1b
`define VCG_OFF_PART_ID 8'h1c

`define VCG_MASK_RST 8'hff
`define VCG_LEVEL_RST 8'hd2
`define VCG_SPI_ADDR_RST 7'h40
`define VCG_CTL_QTR 0
`define VCG_CTL_MUTE 1
`define VCG_ADDR_EN 0

// 2*code + qtr - 420 gives quarter-dB units
`define VCG_QDB_OFFSET 11'sh1a4
`define VCG_QDB_MAX 11'sh058
`define VCG_QDB_MIN 11'sh680

`define VCG_ZC_IMMEDIATE 2'h0
`define VCG_CLK_MHZ 10
`define VCG_TO_BASE_US 2
`define VCG_TO_BASE_CYC 12'(`VCG_TO_BASE_US * `VCG_CLK_MHZ)
`define VCG_TO_MAX_CODE 7
`define VCG_WAIT_MAX 12'(`VCG_TO_BASE_CYC << `VCG_TO_MAX_CODE)

`endif

// ---- rtl/vcg_pkg.sv ----
`default_nettype none
package vcg_pkg;
    typedef logic signed [10:0] vcg_qdb_t;
    typedef enum logic [0:0] {
        VCG_IDLE = 1'b0,
        VCG_WAIT = 1'b1
    } vcg_apply_e;
endpackage
`default_nettype wire

// ---- rtl/vcg_chan_apply.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "vcg_consts.svh"

module vcg_chan_apply (
    input wire logic sys_clk, // system clock
    input wire logic reset, // sync reset, high
    input wire logic include_ch, // channel follows group 3
    input wire vcg_pkg::vcg_qdb_t group_qdb, // clamped group level
    input wire logic group_mute, // group 3 silence
    input wire logic [1:0] zc_mode, // zero cross select
    input wire logic [11:0] timeout_cyc, // wait limit in cycles
    input wire logic zero_cross, // synchronised crossing
    output vcg_pkg::vcg_qdb_t chan_qdb_r, // applied contribution
    output logic chan_mute_r // applied mute
);
    vcg_pkg::vcg_apply_e state_r;
    logic [11:0] wait_cnt_r;
    vcg_pkg::vcg_qdb_t target;
    logic [11:0] wait_age_r;

    // an excluded channel sees neither level nor mute
    assign target = include_ch ? group_qdb : 11'sh000;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            chan_mute_r <= 1'b0;
        end else begin
            chan_mute_r <= include_ch & group_mute;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r <= vcg_pkg::VCG_IDLE;
            chan_qdb_r <= 11'sh000;
            wait_cnt_r <= 12'h000;
        end else begin
            case (state_r)
                vcg_pkg::VCG_IDLE: begin
                    wait_cnt_r <= 12'h000;
                    if (target != chan_qdb_r) begin
                        if (zc_mode == `VCG_ZC_IMMEDIATE) begin
                            chan_qdb_r <= target;
                        end else begin
                            state_r <= vcg_pkg::VCG_WAIT;
                        end
                    end
                end
                vcg_pkg::VCG_WAIT: begin
                    // latest target taken; avoids a stale step
                    wait_cnt_r <= wait_cnt_r + 12'h001;
                    if (zero_cross || wait_cnt_r >= timeout_cyc) begin
                        chan_qdb_r <= target;
                        state_r <= vcg_pkg::VCG_IDLE;
                    end
                end
                default: state_r <= vcg_pkg::VCG_IDLE;
            endcase
        end
    end

    // cycles spent waiting, kept apart from the exit counter
    always_ff @(posedge sys_clk) begin
        if (reset || state_r != vcg_pkg::VCG_WAIT) begin
            wait_age_r <= 12'h000;
        end else begin
            wait_age_r <= wait_age_r + 12'h001;
        end
    end

    property p_excluded_zero;
        @(posedge sys_clk) disable iff (reset)
        (!include_ch && zc_mode == `VCG_ZC_IMMEDIATE
            && state_r == vcg_pkg::VCG_IDLE)
        |=> (chan_qdb_r == 11'sh000) && !chan_mute_r;
    endproperty
    a_excluded_zero: assert property (p_excluded_zero)
        else $error("excluded channel still affected");

    property p_included_mute;
        @(posedge sys_clk) disable iff (reset)
        (include_ch && group_mute) |=> chan_mute_r;
    endproperty
    a_included_mute: assert property (p_included_mute)
        else $error("included channel not muted");

    property p_wait_bounded;
        @(posedge sys_clk) disable iff (reset)
        (state_r == vcg_pkg::VCG_WAIT) |-> (wait_age_r <= `VCG_WAIT_MAX);
    endproperty
    a_wait_bounded: assert property (p_wait_bounded)
        else $error("pending level change never applied");
endmodule
`default_nettype wire

// ---- rtl/vcg_group3_regs.sv ----
// Contract
// - group 2 quarter bit adds quarter dB
// - mask bit one: channel follows group 3
// - mask bit zero: channel unaffected by group
// - mask resets to all ones
// - level steps all included channels half dB
// - code is twice dB plus 210
// - any code accepted, result clamped +22/-96
// - changes follow zero cross mode and timeout; mute applies next cycle without waiting
// - silence bit mutes group, resets zero
// - group 3 quarter bit adds quarter dB
// - second group id, rewritable, SPI reset 40h
// - second group accept gates group 2 hits
// - first group id, rewritable, SPI reset 40h
// - first group accept gates group 1 hits
// - own address, rewritable, SPI reset 40h
// - own address bit 0 drives chain enable
// - identification register read only, code+revision
`timescale 1ns/1ps
`default_nettype none
`include "vcg_consts.svh"

module vcg_group3_regs #(
    parameter logic [6:0] I2C_DEFAULT_ADDR = 7'h00, // strap-table default
    parameter logic [3:0] PART_CODE = 4'h5, // arbitrary value
    parameter logic [3:0] REVISION = 4'h1 // arbitrary value
) (
    input wire logic sys_clk, // 10 MHz clock
    input wire logic reset, // sync reset, high
    input wire logic spi_mode_pin, // high when port runs SPI
    input wire logic reg_wr_en, // write strobe from port
    input wire logic reg_rd_en, // read strobe from port
    input wire logic [7:0] reg_addr, // register offset
    input wire logic [7:0] reg_wdata, // write data
    output logic [7:0] reg_rdata_r, // read data, next cycle
    input wire logic probe_valid, // port saw a chip address
    input wire logic [6:0] probe_addr, // address seen on the bus
    output logic addr_hit_r, // transfer is for this chip
    input wire logic [1:0] zero_cross_select, // from config reg two
    input wire logic [2:0] zc_timeout, // from config reg two
    input wire logic [7:0] chan_zero_cross_pin, // per channel crossing
    output logic chain_enable_output, // next device enable
    output logic group2_quarter_step, // quarter dB for group 2
    output vcg_pkg::vcg_qdb_t group3_qdb_r, // clamped quarter dB level
    output vcg_pkg::vcg_qdb_t chan_qdb_r [8], // per channel contribution
    output logic [7:0] chan_mute_r // per channel group mute
);
    logic [7:0] group3_channel_include;
    logic [7:0] group3_level_code;
    logic group3_silence;
    logic group3_quarter_step;
    logic [6:0] second_group_id;
    logic second_group_accept;
    logic [6:0] first_group_id;
    logic first_group_accept;
    logic [6:0] own_id;
    logic spi_meta_r;
    logic spi_sync_r;
    logic reset_d_r;
    logic [7:0] zc_meta_r;
    logic [7:0] zc_sync_r;
    logic [6:0] addr_rst;
    logic [11:0] timeout_cyc;
    vcg_pkg::vcg_qdb_t raw_qdb;
    logic [7:0] rd_mux;

    // strap is free-running so reset can sample it
    always_ff @(posedge sys_clk) begin
        spi_meta_r <= spi_mode_pin;
        spi_sync_r <= spi_meta_r;
        zc_meta_r <= chan_zero_cross_pin;
        zc_sync_r <= zc_meta_r;
    end

    assign addr_rst = spi_sync_r ? `VCG_SPI_ADDR_RST : I2C_DEFAULT_ADDR;

    // strap may settle only on the last reset edge; reload ids once after
    always_ff @(posedge sys_clk) begin
        reset_d_r <= reset;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            group3_channel_include <= `VCG_MASK_RST;
            group3_level_code <= `VCG_LEVEL_RST;
            group3_silence <= 1'b0;
            group3_quarter_step <= 1'b0;
            group2_quarter_step <= 1'b0;
        end else if (reg_wr_en) begin
            case (reg_addr)
                `VCG_OFF_G2_CTL: begin
                    group2_quarter_step <= reg_wdata[`VCG_CTL_QTR];
                end
                `VCG_OFF_G3_MASK: begin
                    group3_channel_include <= reg_wdata;
                end
                `VCG_OFF_G3_LEVEL: begin
                    group3_level_code <= reg_wdata;
                end
                `VCG_OFF_G3_CTL: begin
                    group3_silence <= reg_wdata[`VCG_CTL_MUTE];
                    group3_quarter_step <= reg_wdata[`VCG_CTL_QTR];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            second_group_id <= addr_rst;
            second_group_accept <= 1'b0;
            first_group_id <= addr_rst;
            first_group_accept <= 1'b0;
            own_id <= addr_rst;
            chain_enable_output <= 1'b0;
        end else begin
            if (reset_d_r) begin
                second_group_id <= addr_rst;
                first_group_id <= addr_rst;
                own_id <= addr_rst;
            end
            // a write in the same cycle wins over the reload
            if (reg_wr_en) begin
                case (reg_addr)
                    `VCG_OFF_SECOND_GROUP_ID: begin
                        second_group_id <= reg_wdata[7:1];
                        second_group_accept <= reg_wdata[`VCG_ADDR_EN];
                    end
                    `VCG_OFF_FIRST_GROUP_ID: begin
                        first_group_id <= reg_wdata[7:1];
                        first_group_accept <= reg_wdata[`VCG_ADDR_EN];
                    end
                    `VCG_OFF_OWN_ADDR: begin
                        own_id <= reg_wdata[7:1];
                        chain_enable_output <= reg_wdata[`VCG_ADDR_EN];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // other offsets belong to neighbouring slices and read as zero here
    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr)
            `VCG_OFF_G2_CTL: rd_mux = {7'h00, group2_quarter_step};
            `VCG_OFF_G3_MASK: rd_mux = group3_channel_include;
            `VCG_OFF_G3_LEVEL: rd_mux = group3_level_code;
            `VCG_OFF_G3_CTL: begin
                rd_mux = {6'h00, group3_silence, group3_quarter_step};
            end
            `VCG_OFF_SECOND_GROUP_ID: rd_mux = {second_group_id, second_group_accept};
            `VCG_OFF_FIRST_GROUP_ID: rd_mux = {first_group_id, first_group_accept};
            `VCG_OFF_OWN_ADDR: rd_mux = {own_id, chain_enable_output};
            `VCG_OFF_PART_ID: rd_mux = {PART_CODE, REVISION};
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_rd_en) begin
            reg_rdata_r <= rd_mux;
        end
    end

    // own address always answers; group addresses only when accepted
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            addr_hit_r <= 1'b0;
        end else begin
            addr_hit_r <= probe_valid && ((probe_addr == own_id)
                || (second_group_accept && probe_addr == second_group_id)
                || (first_group_accept && probe_addr == first_group_id));
        end
    end

    // {code, qtr} is 2*code+qtr, so one subtract gives quarter-dB units
    assign raw_qdb = $signed({2'b00, group3_level_code, group3_quarter_step})
        - `VCG_QDB_OFFSET;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            group3_qdb_r <= 11'sh000;
        end else if (raw_qdb > `VCG_QDB_MAX) begin
            group3_qdb_r <= `VCG_QDB_MAX;
        end else if (raw_qdb < `VCG_QDB_MIN) begin
            group3_qdb_r <= `VCG_QDB_MIN;
        end else begin
            group3_qdb_r <= raw_qdb;
        end
    end

    assign timeout_cyc = `VCG_TO_BASE_CYC << zc_timeout;

    for (genvar ch = 0; ch < 8; ch++) begin : g_chan
        vcg_chan_apply u_apply (
            .sys_clk(sys_clk),
            .reset(reset),
            .include_ch(group3_channel_include[ch]),
            .group_qdb(group3_qdb_r),
            .group_mute(group3_silence),
            .zc_mode(zero_cross_select),
            .timeout_cyc(timeout_cyc),
            .zero_cross(zc_sync_r[ch]),
            .chan_qdb_r(chan_qdb_r[ch]),
            .chan_mute_r(chan_mute_r[ch])
        );
    end

    property p_mask_reset;
        @(posedge sys_clk)
        reset |=> (group3_channel_include == `VCG_MASK_RST);
    endproperty
    a_mask_reset: assert property (p_mask_reset)
        else $error("channel mask not all ones after reset");

    property p_zero_db_reset;
        @(posedge sys_clk)
        reset ##1 reset |=> (group3_qdb_r == 11'sh000) && !group3_silence;
    endproperty
    a_zero_db_reset: assert property (p_zero_db_reset)
        else $error("group level not zero dB after reset");

    property p_clamp_top;
        @(posedge sys_clk) disable iff (reset)
        (reg_wr_en && reg_addr == `VCG_OFF_G3_LEVEL && reg_wdata == 8'hff)
        |=> ##1 (group3_qdb_r == `VCG_QDB_MAX);
    endproperty
    a_clamp_top: assert property (p_clamp_top)
        else $error("level above range not clamped");

    property p_clamp_bottom;
        @(posedge sys_clk) disable iff (reset)
        (reg_wr_en && reg_addr == `VCG_OFF_G3_LEVEL && reg_wdata == 8'h00)
        |=> ##1 (group3_qdb_r == `VCG_QDB_MIN);
    endproperty
    a_clamp_bottom: assert property (p_clamp_bottom)
        else $error("level below range not clamped");

    property p_quarter_adds;
        @(posedge sys_clk) disable iff (reset)
        (reg_wr_en && reg_addr == `VCG_OFF_G3_CTL && reg_wdata[0]
            && group3_level_code == `VCG_LEVEL_RST)
        |=> ##1 (group3_qdb_r == 11'sh001);
    endproperty
    a_quarter_adds: assert property (p_quarter_adds)
        else $error("quarter step not added");

    property p_ctl_reserved;
        @(posedge sys_clk) disable iff (reset)
        (reg_rd_en && reg_addr == `VCG_OFF_G3_CTL)
        |=> (reg_rdata_r[7:2] == 6'h00);
    endproperty
    a_ctl_reserved: assert property (p_ctl_reserved)
        else $error("reserved control bits read non-zero");

    property p_id_read;
        @(posedge sys_clk) disable iff (reset)
        (reg_rd_en && reg_addr == `VCG_OFF_PART_ID)
        |=> (reg_rdata_r == {PART_CODE, REVISION});
    endproperty
    a_id_read: assert property (p_id_read)
        else $error("identification read wrong");

    property p_chain_follows;
        @(posedge sys_clk) disable iff (reset)
        (reg_wr_en && reg_addr == `VCG_OFF_OWN_ADDR)
        |=> (chain_enable_output == $past(reg_wdata[0]));
    endproperty
    a_chain_follows: assert property (p_chain_follows)
        else $error("chain enable does not follow bit 0");

    property p_group1_gate;
        @(posedge sys_clk) disable iff (reset)
        (probe_valid && probe_addr == first_group_id
            && probe_addr != own_id && !first_group_accept
            && !(second_group_accept && probe_addr == second_group_id))
        |=> !addr_hit_r;
    endproperty
    a_group1_gate: assert property (p_group1_gate)
        else $error("disabled first group address answered");

    property p_group2_hit;
        @(posedge sys_clk) disable iff (reset)
        (probe_valid && second_group_accept && probe_addr == second_group_id)
        |=> addr_hit_r;
    endproperty
    a_group2_hit: assert property (p_group2_hit)
        else $error("enabled second group address ignored");

    property p_spi_addr_reset;
        @(posedge sys_clk)
        ($fell(reset) && spi_sync_r && !reg_wr_en)
        |=> (own_id == `VCG_SPI_ADDR_RST)
            && (first_group_id == `VCG_SPI_ADDR_RST)
            && (second_group_id == `VCG_SPI_ADDR_RST);
    endproperty
    a_spi_addr_reset: assert property (p_spi_addr_reset)
        else $error("SPI default address wrong");

    property p_i2c_addr_reset;
        @(posedge sys_clk)
        ($fell(reset) && !spi_sync_r && !reg_wr_en)
        |=> (own_id == I2C_DEFAULT_ADDR)
            && (first_group_id == I2C_DEFAULT_ADDR)
            && (second_group_id == I2C_DEFAULT_ADDR);
    endproperty
    a_i2c_addr_reset: assert property (p_i2c_addr_reset)
        else $error("I2C default address wrong");
endmodule
`default_nettype wire

// ---- dv/vcg_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "vcg_consts.svh"

module vcg_host_model (
    input wire logic sys_clk, // system clock
    input wire logic [7:0] reg_rdata_r, // read data
    input wire logic addr_hit_r, // match answer
    output logic reg_wr_en, // write strobe
    output logic reg_rd_en, // read strobe
    output logic [7:0] reg_addr, // register offset
    output logic [7:0] reg_wdata, // write data
    output logic probe_valid, // address seen
    output logic [6:0] probe_addr // address on the bus
);
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        probe_valid = 1'b0;
        probe_addr = 7'h00;
    end
    // released lines show the inverse so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge sys_clk);
        #1;
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(posedge sys_clk);
        #1;
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        d = reg_rdata_r;
    endtask
    task automatic probe(input logic [6:0] a, output logic h);
        @(posedge sys_clk);
        #1;
        probe_valid = 1'b1;
        probe_addr = a;
        @(posedge sys_clk);
        #1;
        probe_valid = 1'b0;
        probe_addr = ~a;
        h = addr_hit_r;
    endtask
    // floor to half dB, the odd quarter goes to the quarter bit
    task automatic wr_level(input int qdb, input logic mute);
        wr(`VCG_OFF_G3_LEVEL, 8'(210 + (qdb >>> 1)));
        wr(`VCG_OFF_G3_CTL, {6'h00, mute, qdb[0]});
    endtask
endmodule
`default_nettype wire

// ---- dv/master_group_address_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "vcg_consts.svh"

module master_group_address_regs_tb;
    localparam logic [3:0] PCODE = 4'h9; // arbitrary value
    localparam logic [3:0] PREV = 4'h3; // arbitrary value
    localparam logic [6:0] I2CA = 7'h2a; // arbitrary value
    logic sys_clk, reset, spi_mode_pin, reg_wr_en, reg_rd_en, probe_valid;
    logic [7:0] reg_addr, reg_wdata, reg_rdata_r, chan_zero_cross_pin;
    logic [7:0] chan_mute_r;
    logic [6:0] probe_addr;
    logic [1:0] zero_cross_select;
    logic [2:0] zc_timeout;
    logic addr_hit_r, chain_enable_output, group2_quarter_step;
    vcg_pkg::vcg_qdb_t group3_qdb_r;
    vcg_pkg::vcg_qdb_t chan_qdb_r [8];
    int err_count = 0;
    int n_tests = 0;

    vcg_group3_regs #(.I2C_DEFAULT_ADDR(I2CA), .PART_CODE(PCODE),
        .REVISION(PREV)) u_vcg_group3_regs (
        .sys_clk(sys_clk), .reset(reset), .spi_mode_pin(spi_mode_pin),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
        .probe_valid(probe_valid), .probe_addr(probe_addr),
        .addr_hit_r(addr_hit_r), .zero_cross_select(zero_cross_select),
        .zc_timeout(zc_timeout), .chan_zero_cross_pin(chan_zero_cross_pin),
        .chain_enable_output(chain_enable_output),
        .group2_quarter_step(group2_quarter_step),
        .group3_qdb_r(group3_qdb_r), .chan_qdb_r(chan_qdb_r),
        .chan_mute_r(chan_mute_r));

    vcg_host_model u_vcg_host_model (
        .sys_clk(sys_clk), .reg_rdata_r(reg_rdata_r),
        .addr_hit_r(addr_hit_r), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .probe_valid(probe_valid), .probe_addr(probe_addr));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic finish_test();
        if (err_count == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic check(input string n, input logic [10:0] seen,
                         input logic [10:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_vcg_host_model.rd(a, d);
        check($sformatf("reg %h", a), {3'h0, d}, {3'h0, exp});
    endtask

    task automatic pchk(input logic [6:0] a, input logic exp);
        logic h;
        u_vcg_host_model.probe(a, h);
        check($sformatf("hit %h", a), {10'h0, h}, {10'h0, exp});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic t_reset();
        rchk(`VCG_OFF_G3_MASK, 8'hff);
        rchk(`VCG_OFF_G3_LEVEL, 8'hd2);
        rchk(`VCG_OFF_G3_CTL, 8'h00);
        rchk(`VCG_OFF_SECOND_GROUP_ID, 8'h80);
        rchk(`VCG_OFF_FIRST_GROUP_ID, 8'h80);
        rchk(`VCG_OFF_OWN_ADDR, 8'h80);
        rchk(`VCG_OFF_PART_ID, {PCODE, PREV});
        check("chain", {10'h0, chain_enable_output}, 11'h000);
        check("g3 level", group3_qdb_r, 11'h000);
    endtask

    task automatic t_access();
        u_vcg_host_model.wr(`VCG_OFF_G3_CTL, 8'hff);
        rchk(`VCG_OFF_G3_CTL, 8'h03);
        u_vcg_host_model.wr(`VCG_OFF_G2_CTL, 8'hff);
        check("q2", {10'h0, group2_quarter_step}, 11'h001);
        rchk(`VCG_OFF_G2_CTL, 8'h01);
        u_vcg_host_model.wr(`VCG_OFF_G2_CTL, 8'h00);
        check("q2", {10'h0, group2_quarter_step}, 11'h000);
        u_vcg_host_model.wr(`VCG_OFF_PART_ID, 8'h00);
        rchk(`VCG_OFF_PART_ID, {PCODE, PREV});
        rchk(8'h30, 8'h00);
        u_vcg_host_model.wr(`VCG_OFF_G3_CTL, 8'h00);
    endtask

    task automatic t_levels();
        int tg [4] = '{1, -3, 40, 88};
        foreach (tg[i]) begin
            u_vcg_host_model.wr_level(tg[i], 1'b0);
            settle(3);
            check("g3 level", group3_qdb_r, 11'(tg[i]));
            check("ch1", chan_qdb_r[0], 11'(tg[i]));
            check("ch8", chan_qdb_r[7], 11'(tg[i]));
        end
        u_vcg_host_model.wr(`VCG_OFF_G3_CTL, 8'h00);
        u_vcg_host_model.wr(`VCG_OFF_G3_LEVEL, 8'hff);
        settle(3);
        check("g3 top", group3_qdb_r, 11'h058);
        u_vcg_host_model.wr(`VCG_OFF_G3_LEVEL, 8'h00);
        settle(3);
        check("g3 bottom", group3_qdb_r, 11'h680);
        check("ch4", chan_qdb_r[3], 11'h680);
    endtask

    task automatic t_mask();
        u_vcg_host_model.wr(`VCG_OFF_G3_MASK, 8'h0f);
        u_vcg_host_model.wr_level(40, 1'b1);
        settle(3);
        check("mute", {3'h0, chan_mute_r}, 11'h00f);
        check("ch1", chan_qdb_r[0], 11'd40);
        check("ch8", chan_qdb_r[7], 11'h000);
        u_vcg_host_model.wr(`VCG_OFF_G3_CTL, 8'h00);
        settle(2);
        check("mute", {3'h0, chan_mute_r}, 11'h000);
        u_vcg_host_model.wr(`VCG_OFF_G3_MASK, 8'hff);
        settle(3);
    endtask

    task automatic t_zero_cross();
        zero_cross_select = 2'h1;
        u_vcg_host_model.wr_level(-20, 1'b0);
        chan_zero_cross_pin = 8'h01;
        settle(2);
        chan_zero_cross_pin = 8'h00;
        settle(4);
        check("ch1 zc", chan_qdb_r[0], -11'sd20);
        check("ch2 wait", chan_qdb_r[1], 11'd40);
        settle(25);
        check("ch2 timeout", chan_qdb_r[1], -11'sd20);
        zc_timeout = 3'h1;
        u_vcg_host_model.wr_level(8, 1'b0);
        settle(30);
        check("ch2 wait", chan_qdb_r[1], -11'sd20);
        settle(15);
        check("ch2 timeout", chan_qdb_r[1], 11'd8);
        zc_timeout = 3'h0;
        zero_cross_select = 2'h0;
    endtask

    task automatic t_rerun();
        u_vcg_host_model.wr(`VCG_OFF_G3_MASK, 8'h00);
        u_vcg_host_model.wr(`VCG_OFF_OWN_ADDR, {7'h11, 1'b1});
        spi_mode_pin = 1'b0;
        reset = 1'b1;
        settle(2);
        reset = 1'b0;
        check("g3 level", group3_qdb_r, 11'h000);
        check("chain", {10'h0, chain_enable_output}, 11'h000);
        rchk(`VCG_OFF_G3_MASK, 8'hff);
        rchk(`VCG_OFF_OWN_ADDR, {I2CA, 1'b0});
        rchk(`VCG_OFF_FIRST_GROUP_ID, {I2CA, 1'b0});
        rchk(`VCG_OFF_SECOND_GROUP_ID, {I2CA, 1'b0});
        pchk(I2CA, 1'b1);
        pchk(7'h11, 1'b0);
    endtask

    task automatic t_address();
        u_vcg_host_model.wr(`VCG_OFF_OWN_ADDR, {7'h11, 1'b1});
        check("chain", {10'h0, chain_enable_output}, 11'h001);
        pchk(7'h11, 1'b1);
        u_vcg_host_model.wr(`VCG_OFF_FIRST_GROUP_ID, {7'h22, 1'b0});
        pchk(7'h22, 1'b0);
        u_vcg_host_model.wr(`VCG_OFF_FIRST_GROUP_ID, {7'h22, 1'b1});
        pchk(7'h22, 1'b1);
        u_vcg_host_model.wr(`VCG_OFF_SECOND_GROUP_ID, {7'h33, 1'b0});
        pchk(7'h33, 1'b0);
        u_vcg_host_model.wr(`VCG_OFF_SECOND_GROUP_ID, {7'h33, 1'b1});
        pchk(7'h33, 1'b1);
        pchk(7'h44, 1'b0);
        u_vcg_host_model.wr(`VCG_OFF_OWN_ADDR, {7'h11, 1'b0});
        check("chain", {10'h0, chain_enable_output}, 11'h000);
    endtask

    initial begin
        #(20000 * 100);
        err_count++;
        finish_test();
    end

    initial begin
        reset = 1'b1;
        spi_mode_pin = 1'b1;
        zero_cross_select = 2'h0;
        zc_timeout = 3'h0;
        chan_zero_cross_pin = 8'h00;
        repeat (2) @(posedge sys_clk);
        #1;
        reset = 1'b0;
        t_reset();
        t_access();
        t_levels();
        t_mask();
        t_zero_cross();
        t_address();
        t_rerun();
        finish_test();
    end
endmodule
`default_nettype wire
